// ---- verilog/eirq_ctrl.sv ----
// External and internal interrupt request controller with reset entry handling.
`timescale 1ns/1ns

// Notes on behaviour
// [RULE1] Each wake pin has an edge bit: 0 falling, 1 rising; resets 0.
// [RULE2] Enable bit 7 gates the direct-transition request; resets 0.
// [RULE3] Enable bit 6 gates the timer overflow request; resets 0.
// [RULE4] Enable bit 5 is one common enable for all six wake requests.
// [RULE5] Enable bits 3..0 enable the four vectored pins, pin n to bit n.
// [RULE6] Reserved bits of enable and both flag registers read as 1.
// [RULE7] A request colliding with a clear while unmasked is still taken afterwards.
// [RULE8] Software should clear enables or flags only while the CPU mask is 1.
// [RULE9] Flag bit 7 sets on a sleep direct transfer with transfer-on set.
// [RULE10] Flag bit 6 sets on timer overflow and stays until written 0.
// [RULE11] Flag bits 3..0 set on the selected edge of an interrupt-mode pin.
// [RULE12] Flags clear only by writing 0; writing 1 changes nothing.
// [RULE13] Wake flag bits 5..0 set on selected edge of an interrupt-mode wake pin.
// [RULE14] Each vectored pin has its own request line and own edge bit.
// [RULE15] All six wake pins share one request line, detected individually.
// [RULE16] The nonmaskable pin edge is selectable and ignores the CPU mask.
// [RULE17] While reset is low all processing halts and registers reset.
// [RULE18] A running device needs reset held low at least 10 clocks.
// [RULE19] At power-up reset stays low until the clock is stable.
// [RULE20] After reset: set the CPU mask, then fetch the vector at 0000-0001.
// [RULE21] Vectored pin edge bits: 0 falling, 1 rising; reset 0.
// [RULE22] Nonmaskable edge bit: 0 falling, 1 rising; reset 0.
// [RULE23] A request goes out only while flag and enable are both 1, or while held after a colliding clear.
// [RULE24] A set event in the same cycle as a clear leaves the flag set.
module eirq_ctrl (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [eirq_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic nonmaskable_pin,
   input wire logic [eirq_pkg::NUM_VEC_PINS-1:0] vectored_pin,
   input wire logic [eirq_pkg::NUM_WAKE_PINS-1:0] wake_pin,
   input wire logic timer_overflow,
   input wire logic sleep_direct_transfer,
   input wire logic cpu_imask,
   input wire logic [eirq_pkg::NUM_SRC-1:0] cpu_int_ack,
   input wire logic cpu_nmi_ack,
   output logic [eirq_pkg::NUM_SRC-1:0] int_req,
   output logic nmi_req,
   output logic cpu_halt,
   output logic cpu_imask_set,
   output logic vector_fetch,
   output logic [15:0] vector_addr,
   output logic cpu_run
);
   import eirq_pkg::*;

   localparam int EDGE_W = 1 + NUM_VEC_PINS + NUM_WAKE_PINS;

   // ************************************************************
   // Registers and internal signals.
   // ************************************************************
   logic [7:0] edge_one_r;
   logic [7:0] wake_edge_select_r;
   logic [7:0] interrupt_enable_one_r;
   logic [7:0] interrupt_flag_one_r;
   logic [7:0] wake_flag_r;
   logic [16:0] pin_cfg_r;
   logic [7:0] enable_nxt;
   logic [7:0] flag_one_nxt;
   logic [7:0] wake_flag_nxt;
   logic [NUM_SRC-1:0] hold_r;
   logic [NUM_SRC-1:0] req_r;
   logic [NUM_SRC-1:0] src_act;
   logic [NUM_SRC-1:0] src_nxt;
   logic nmi_req_r;
   logic waitreq_r;
   logic [31:0] rdata_r;
   logic [31:0] rd_mux;
   logic wr_acc;
   logic wr_lane;
   logic [EDGE_W-1:0] edge_sel_all;
   logic [EDGE_W-1:0] edge_pulse;
   logic nmi_edge;
   logic [NUM_VEC_PINS-1:0] vec_edge;
   logic [NUM_WAKE_PINS-1:0] wake_edge;
   logic [NUM_VEC_PINS-1:0] vec_mode;
   logic [NUM_WAKE_PINS-1:0] wake_mode;
   logic direct_transfer_on;
   logic [7:0] flag_one_set;
   logic [7:0] wake_flag_set;
   logic [7:0] flag_one_clr;
   logic [7:0] wake_flag_clr;
   eirq_rst_state_t rst_state;

   assign vec_mode = pin_cfg_r[NUM_VEC_PINS-1:0];
   assign wake_mode = pin_cfg_r[CFG_WAKE_LSB +: NUM_WAKE_PINS];
   assign direct_transfer_on = pin_cfg_r[CFG_DIRECT_TRANSFER_ON];

   // ************************************************************
   // Pin edge detection.
   // ************************************************************
   assign edge_sel_all = {edge_one_r[BIT_NMI_EDGE], edge_one_r[NUM_VEC_PINS-1:0],
      wake_edge_select_r[NUM_WAKE_PINS-1:0]}; // [RULE1] [RULE21] [RULE22]

   eirq_edge_det #(
      .WIDTH(EDGE_W)
   ) u_edge (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pin_in({nonmaskable_pin, vectored_pin, wake_pin}),
      .edge_sel(edge_sel_all),
      .edge_pulse(edge_pulse)
   ); // [RULE23]

   assign nmi_edge = edge_pulse[EDGE_W-1];
   assign vec_edge = edge_pulse[NUM_WAKE_PINS +: NUM_VEC_PINS];
   assign wake_edge = edge_pulse[NUM_WAKE_PINS-1:0];

   // ************************************************************
   // Reset entry sequence.
   // ************************************************************
   eirq_reset_seq u_rst (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .cpu_halt(cpu_halt),
      .cpu_imask_set(cpu_imask_set),
      .vector_fetch(vector_fetch),
      .vector_addr(vector_addr),
      .cpu_run(cpu_run),
      .state(rst_state)
   );

   // ************************************************************
   // Avalon-MM slave handshake: one wait cycle, then the access completes.
   // ************************************************************
   assign wr_acc = avs_write && !waitreq_r;
   assign wr_lane = wr_acc && avs_byteenable[0];

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         waitreq_r <= 1'b1;
      end else if (!waitreq_r) begin
         waitreq_r <= 1'b1;
      end else if (avs_read || avs_write) begin
         waitreq_r <= 1'b0;
      end
   end

   always_comb begin
      case (avs_address)
         OFS_EDGE_ONE: rd_mux = {24'h000000, edge_one_r | EDGE_ONE_RSV};
         OFS_WAKE_EDGE: rd_mux = {24'h000000, wake_edge_select_r | WAKE_EDGE_RSV};
         OFS_ENABLE: rd_mux = {24'h000000, interrupt_enable_one_r | ENABLE_RSV}; // [RULE6]
         OFS_FLAG_ONE: rd_mux = {24'h000000, interrupt_flag_one_r | FLAG_ONE_RSV}; // [RULE6]
         OFS_WAKE_FLAG: rd_mux = {24'h000000, wake_flag_r | WAKE_FLAG_RSV}; // [RULE6]
         OFS_PIN_CFG: rd_mux = {15'h0000, pin_cfg_r};
         OFS_STATUS: rd_mux = {20'h00000, rst_state, nmi_req_r, hold_r[3:0] != 4'h0,
            req_r};
         default: rd_mux = UNMAPPED_RDATA;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= UNMAPPED_RDATA;
      end else if (avs_read && waitreq_r) begin
         rdata_r <= rd_mux;
      end
   end

   // ************************************************************
   // Edge select, enable and pin configuration registers.
   // ************************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         edge_one_r <= REG8_RST; // [RULE21] [RULE22]
         wake_edge_select_r <= REG8_RST; // [RULE1]
      end else if (wr_lane && avs_address == OFS_EDGE_ONE) begin
         edge_one_r <= avs_writedata[7:0] & EDGE_ONE_WMASK;
      end else if (wr_lane && avs_address == OFS_WAKE_EDGE) begin
         wake_edge_select_r <= avs_writedata[7:0] & WAKE_EDGE_WMASK;
      end
   end

   always_comb begin
      enable_nxt = interrupt_enable_one_r;
      if (wr_lane && avs_address == OFS_ENABLE) begin
         enable_nxt = avs_writedata[7:0] & ENABLE_WMASK;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         interrupt_enable_one_r <= REG8_RST; // [RULE2] [RULE3] [RULE5]
      end else begin
         interrupt_enable_one_r <= enable_nxt;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_cfg_r <= PIN_CFG_RST;
      end else if (wr_acc && avs_address == OFS_PIN_CFG) begin
         if (avs_byteenable[0]) begin
            pin_cfg_r[7:0] <= avs_writedata[7:0] & PIN_CFG_WMASK[7:0];
         end
         if (avs_byteenable[1]) begin
            pin_cfg_r[15:8] <= avs_writedata[15:8] & PIN_CFG_WMASK[15:8];
         end
         if (avs_byteenable[2]) begin
            pin_cfg_r[16] <= avs_writedata[16];
         end
      end
   end

   // ************************************************************
   // Request flags: set by events, cleared only by writing 0; set wins.
   // ************************************************************
   assign flag_one_set = {sleep_direct_transfer & direct_transfer_on, // [RULE9]
      timer_overflow, 2'b00, // [RULE10]
      vec_edge & vec_mode}; // [RULE11]
   assign wake_flag_set = {2'b00, wake_edge & wake_mode}; // [RULE13] [RULE15]
   assign flag_one_clr = (wr_lane && avs_address == OFS_FLAG_ONE) ?
      (~avs_writedata[7:0] & FLAG_ONE_WMASK) : 8'h00; // [RULE12]
   assign wake_flag_clr = (wr_lane && avs_address == OFS_WAKE_FLAG) ?
      (~avs_writedata[7:0] & WAKE_FLAG_WMASK) : 8'h00; // [RULE12]

   always_comb begin
      flag_one_nxt = (interrupt_flag_one_r & ~flag_one_clr) | flag_one_set; // [RULE24]
      wake_flag_nxt = (wake_flag_r & ~wake_flag_clr) | wake_flag_set; // [RULE24]
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         interrupt_flag_one_r <= REG8_RST;
         wake_flag_r <= REG8_RST;
      end else begin
         interrupt_flag_one_r <= flag_one_nxt;
         wake_flag_r <= wake_flag_nxt;
      end
   end

   // ************************************************************
   // Request forwarding toward the CPU.
   // ************************************************************
   assign src_act = {interrupt_flag_one_r[BIT_DT] & interrupt_enable_one_r[BIT_DT], // [RULE2]
      interrupt_flag_one_r[BIT_TMR] & interrupt_enable_one_r[BIT_TMR], // [RULE3]
      (|wake_flag_r) & interrupt_enable_one_r[BIT_WAKE_EN], // [RULE4] [RULE15]
      interrupt_flag_one_r[3:0] & interrupt_enable_one_r[3:0]}; // [RULE5] [RULE14] [RULE23]
   assign src_nxt = {flag_one_nxt[BIT_DT] & enable_nxt[BIT_DT],
      flag_one_nxt[BIT_TMR] & enable_nxt[BIT_TMR],
      (|wake_flag_nxt) & enable_nxt[BIT_WAKE_EN],
      flag_one_nxt[3:0] & enable_nxt[3:0]};

   // A clear that removes a live request while unmasked keeps it until taken.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hold_r <= '0;
      end else begin
         hold_r <= (hold_r & ~cpu_int_ack) |
            (req_r & ~src_nxt & {NUM_SRC{wr_acc && !cpu_imask}}); // [RULE7]
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         req_r <= '0;
      end else begin
         req_r <= src_act | hold_r; // [RULE7] [RULE23]
      end
   end

   // The nonmaskable request is not gated by any enable or by the CPU mask.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         nmi_req_r <= 1'b0;
      end else begin
         nmi_req_r <= (nmi_req_r & ~cpu_nmi_ack) | nmi_edge; // [RULE16]
      end
   end

   assign int_req = req_r;
   assign nmi_req = nmi_req_r;
   assign avs_waitrequest = waitreq_r;
   assign avs_readdata = rdata_r;

   // ************************************************************
   // Checks.
   // ************************************************************
   AST_SET_WINS_CLEAR: assert property ( // [RULE24]
      @(posedge clk_sys) disable iff (!rst_n)
      timer_overflow && flag_one_clr[BIT_TMR] |=> interrupt_flag_one_r[BIT_TMR])
      else $error("timer flag lost when set met clear");

   AST_TIMER_FLAG_STICKY: assert property ( // [RULE10]
      @(posedge clk_sys) disable iff (!rst_n)
      timer_overflow |=> interrupt_flag_one_r[BIT_TMR] ##1
         (interrupt_flag_one_r[BIT_TMR] || $past(flag_one_clr[BIT_TMR])))
      else $error("timer flag did not set or fell without a clear");

   AST_WRITE_ONE_KEEPS: assert property ( // [RULE12]
      @(posedge clk_sys) disable iff (!rst_n)
      wr_lane && avs_address == OFS_WAKE_FLAG && avs_writedata[0] && !wake_flag_set[0]
      |=> wake_flag_r[0] == $past(wake_flag_r[0]))
      else $error("writing one changed a wake flag");

   AST_TIMER_GATED: assert property ( // [RULE3]
      @(posedge clk_sys) disable iff (!rst_n)
      !interrupt_enable_one_r[BIT_TMR] && !hold_r[SRC_TMR] |=> !req_r[SRC_TMR])
      else $error("timer request forwarded while disabled");

   AST_WAKE_GATED: assert property ( // [RULE4]
      @(posedge clk_sys) disable iff (!rst_n)
      !interrupt_enable_one_r[BIT_WAKE_EN] && !hold_r[SRC_WAKE] |=> !req_r[SRC_WAKE])
      else $error("wake request forwarded while common enable is off");

   AST_RESERVED_ONES: assert property ( // [RULE6]
      @(posedge clk_sys) disable iff (!rst_n)
      avs_read && waitreq_r && avs_address == OFS_FLAG_ONE
      |=> !waitreq_r && avs_readdata[5:4] == 2'b11)
      else $error("reserved flag bits did not read as one");

   AST_DIRECT_FLAG: assert property ( // [RULE9]
      @(posedge clk_sys) disable iff (!rst_n)
      sleep_direct_transfer && direct_transfer_on |=> interrupt_flag_one_r[BIT_DT])
      else $error("direct transition flag not set");

   AST_NMI_RAISE: assert property ( // [RULE16]
      @(posedge clk_sys) disable iff (!rst_n)
      nmi_edge |=> nmi_req_r)
      else $error("nonmaskable edge did not raise a request");

   AST_CLEAR_COLLISION: assert property ( // [RULE7]
      @(posedge clk_sys) disable iff (!rst_n)
      req_r[0] && wr_acc && !cpu_imask && !src_nxt[0] && !cpu_int_ack[0]
      |=> req_r[0] && hold_r[0] ##1 (req_r[0] || $past(cpu_int_ack[0])))
      else $error("request dropped by a colliding clear");

   AST_VEC_FLAG_MODE: assert property ( // [RULE11]
      @(posedge clk_sys) disable iff (!rst_n)
      vec_edge[0] && !vec_mode[0] && !interrupt_flag_one_r[0] |=> !interrupt_flag_one_r[0])
      else $error("vectored flag set while pin not in interrupt mode");

endmodule

// ---- verilog/eirq_pkg.sv ----
// Shared constants and types of the external interrupt and reset entry controller.
package eirq_pkg;

   // ************************************************************
   // Register bus geometry and register byte offsets.
   // ************************************************************
   localparam int ADDR_W = 5;
   localparam logic [ADDR_W-1:0] OFS_EDGE_ONE = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_WAKE_EDGE = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_ENABLE = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_FLAG_ONE = 5'h0C;
   localparam logic [ADDR_W-1:0] OFS_WAKE_FLAG = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_PIN_CFG = 5'h14;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h18;

   // ************************************************************
   // Field positions, writable masks and reserved read-as-one bits.
   // ************************************************************
   localparam int NUM_VEC_PINS = 4;
   localparam int NUM_WAKE_PINS = 6;
   localparam int NUM_SRC = 7;
   localparam int BIT_NMI_EDGE = 7;
   localparam int BIT_DT = 7;
   localparam int BIT_TMR = 6;
   localparam int BIT_WAKE_EN = 5;
   localparam int SRC_WAKE = 4;
   localparam int SRC_TMR = 5;
   localparam int SRC_DT = 6;
   localparam int CFG_WAKE_LSB = 8;
   localparam int CFG_DIRECT_TRANSFER_ON = 16;
   localparam logic [7:0] EDGE_ONE_WMASK = 8'h8F;
   localparam logic [7:0] EDGE_ONE_RSV = 8'h70;
   localparam logic [7:0] WAKE_EDGE_WMASK = 8'h3F;
   localparam logic [7:0] WAKE_EDGE_RSV = 8'hC0;
   localparam logic [7:0] ENABLE_WMASK = 8'hEF;
   localparam logic [7:0] ENABLE_RSV = 8'h10;
   localparam logic [7:0] FLAG_ONE_WMASK = 8'hCF;
   localparam logic [7:0] FLAG_ONE_RSV = 8'h30;
   localparam logic [7:0] WAKE_FLAG_WMASK = 8'h3F;
   localparam logic [7:0] WAKE_FLAG_RSV = 8'hC0;
   localparam logic [16:0] PIN_CFG_WMASK = 17'h13F0F;

   // ************************************************************
   // Reset values.
   // ************************************************************
   localparam logic [7:0] REG8_RST = 8'h00;
   localparam logic [16:0] PIN_CFG_RST = 17'h00000;
   localparam logic [31:0] UNMAPPED_RDATA = 32'h00000000;

   // ************************************************************
   // Reset entry sequence.
   // ************************************************************
   localparam logic [15:0] RESET_VECTOR_HI = 16'h0000;
   localparam logic [15:0] RESET_VECTOR_LO = 16'h0001;
   localparam int SYNC_ARM_CYCLES = 3;

   typedef enum logic [2:0] {
      EIRQ_RS_HALT = 3'b000,
      EIRQ_RS_MASK = 3'b001,
      EIRQ_RS_FETCH_HI = 3'b010,
      EIRQ_RS_FETCH_LO = 3'b011,
      EIRQ_RS_RUN = 3'b100
   } eirq_rst_state_t;

endpackage

// ---- verilog/eirq_edge_det.sv ----
// Pin synchroniser and selectable rising or falling edge detector.
`timescale 1ns/1ns
module eirq_edge_det #(
   parameter int WIDTH = 11
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] pin_in,
   input wire logic [WIDTH-1:0] edge_sel,
   output logic [WIDTH-1:0] edge_pulse
);
   import eirq_pkg::*;

   logic [WIDTH-1:0] sync1_r;
   logic [WIDTH-1:0] sync2_r;
   logic [WIDTH-1:0] prev_r;
   logic [WIDTH-1:0] edge_r;
   logic [SYNC_ARM_CYCLES-1:0] arm_r;

   // Pins idle high; arming hides the false edge of a pin held low at reset.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= '1;
         sync2_r <= '1;
         prev_r <= '1;
         arm_r <= '0;
      end else begin
         sync1_r <= pin_in;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
         arm_r <= {arm_r[SYNC_ARM_CYCLES-2:0], 1'b1};
      end
   end

   // ************************************************************
   // Per-pin edge compare.
   // ************************************************************
   for (genvar i = 0; i < WIDTH; i++) begin : g_edge
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            edge_r[i] <= 1'b0;
         end else begin
            edge_r[i] <= arm_r[SYNC_ARM_CYCLES-1] &
               (edge_sel[i] ? (sync2_r[i] & ~prev_r[i]) : (~sync2_r[i] & prev_r[i]));
         end
      end
   end

   assign edge_pulse = edge_r;

endmodule

// ---- verilog/eirq_reset_seq.sv ----
// Reset exception entry sequencer: halt, set mask, fetch reset vector, run.
`timescale 1ns/1ns
module eirq_reset_seq (
   input wire logic clk_sys,
   input wire logic rst_n,
   output logic cpu_halt,
   output logic cpu_imask_set,
   output logic vector_fetch,
   output logic [15:0] vector_addr,
   output logic cpu_run,
   output eirq_pkg::eirq_rst_state_t state
);
   import eirq_pkg::*;

   eirq_rst_state_t state_r;
   logic halt_r;
   logic mask_set_r;
   logic fetch_r;
   logic [15:0] addr_r;
   logic run_r;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= EIRQ_RS_HALT; // [RULE17]
         halt_r <= 1'b1;
         mask_set_r <= 1'b0;
         fetch_r <= 1'b0;
         addr_r <= RESET_VECTOR_HI;
         run_r <= 1'b0;
      end else begin
         mask_set_r <= 1'b0;
         fetch_r <= 1'b0;
         case (state_r)
            EIRQ_RS_HALT: begin
               state_r <= EIRQ_RS_MASK;
               mask_set_r <= 1'b1; // [RULE20]
            end
            EIRQ_RS_MASK: begin
               state_r <= EIRQ_RS_FETCH_HI;
               fetch_r <= 1'b1;
               addr_r <= RESET_VECTOR_HI; // [RULE20]
            end
            EIRQ_RS_FETCH_HI: begin
               state_r <= EIRQ_RS_FETCH_LO;
               fetch_r <= 1'b1;
               addr_r <= RESET_VECTOR_LO;
            end
            EIRQ_RS_FETCH_LO: begin
               state_r <= EIRQ_RS_RUN;
               halt_r <= 1'b0;
               run_r <= 1'b1;
            end
            EIRQ_RS_RUN: begin
               state_r <= EIRQ_RS_RUN;
            end
            default: begin
               state_r <= EIRQ_RS_HALT;
            end
         endcase
      end
   end

   AST_MASK_BEFORE_FETCH: assert property ( // [RULE20]
      @(posedge clk_sys) disable iff (!rst_n)
      $rose(fetch_r) |-> $past(mask_set_r) && addr_r == RESET_VECTOR_HI ##1 fetch_r
         && addr_r == RESET_VECTOR_LO ##1 run_r)
      else $error("reset vector fetch not preceded by mask set");

   assign cpu_halt = halt_r;
   assign cpu_imask_set = mask_set_r;
   assign vector_fetch = fetch_r;
   assign vector_addr = addr_r;
   assign cpu_run = run_r;
   assign state = state_r;

endmodule

// ---- verification/eirq_cpu_model.sv ----
// Behavioural CPU core that answers requests with acknowledge pulses.
`timescale 1ns/1ns
module eirq_cpu_model #(
   parameter int ACK_DELAY = 8
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [eirq_pkg::NUM_SRC-1:0] int_req,
   input wire logic nmi_req,
   input wire logic cpu_imask,
   output logic [eirq_pkg::NUM_SRC-1:0] cpu_int_ack,
   output logic cpu_nmi_ack
);
   import eirq_pkg::*;
   int wait_r;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wait_r <= 0;
         cpu_int_ack <= '0;
         cpu_nmi_ack <= 1'b0;
      end else if (wait_r == ACK_DELAY) begin
         wait_r <= 0;
         cpu_nmi_ack <= nmi_req;
         cpu_int_ack <= cpu_imask ? '0 : int_req;
      end else begin
         cpu_int_ack <= '0;
         cpu_nmi_ack <= 1'b0;
         wait_r <= (nmi_req || (!cpu_imask && int_req != '0)) ? wait_r + 1 : 0;
      end
   end
endmodule

// ---- verification/testbench.sv ----
// Self-checking testbench of the interrupt controller beside a CPU model.
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
   $display("Error %0t: got %h exp %h", $time, a, b); end end
module testbench;
   import eirq_pkg::*;
   logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, nonmaskable_pin;
   logic timer_overflow, sleep_direct_transfer, cpu_imask, nmi_req, cpu_nmi_ack;
   logic cpu_halt, cpu_imask_set, vector_fetch, cpu_run;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [3:0] vectored_pin;
   logic [5:0] wake_pin;
   logic [6:0] int_req, cpu_int_ack;
   logic [15:0] vector_addr;
   int err_count = 0;
   int total_checks = 0;
   eirq_ctrl eirq_ctrl_inst (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .nonmaskable_pin(nonmaskable_pin), .vectored_pin(vectored_pin), .wake_pin(wake_pin),
      .timer_overflow(timer_overflow), .sleep_direct_transfer(sleep_direct_transfer),
      .cpu_imask(cpu_imask), .cpu_int_ack(cpu_int_ack), .cpu_nmi_ack(cpu_nmi_ack),
      .int_req(int_req), .nmi_req(nmi_req), .cpu_halt(cpu_halt),
      .cpu_imask_set(cpu_imask_set), .vector_fetch(vector_fetch),
      .vector_addr(vector_addr), .cpu_run(cpu_run));
   eirq_cpu_model eirq_cpu_model_inst (.clk_sys(clk_sys), .rst_n(rst_n), .int_req(int_req),
      .nmi_req(nmi_req), .cpu_imask(cpu_imask), .cpu_int_ack(cpu_int_ack),
      .cpu_nmi_ack(cpu_nmi_ack));
   task automatic print_verdict;
      if (err_count == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 20) begin
         err_count++;
         $display("Error %0t: bus timeout", $time);
         print_verdict;
      end
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      bus(1'b0, a, 32'h0);
      `CHK(q[7:0], e)
   endtask
   task automatic settle;
      repeat (8) @(posedge clk_sys);
      #1;
   endtask
   task automatic reset_entry;
      @(posedge clk_sys);
      #1 `CHK(cpu_imask_set, 1'b1)
      @(posedge clk_sys);
      #1 `CHK({vector_fetch, vector_addr}, {1'b1, RESET_VECTOR_HI})
      @(posedge clk_sys);
      #1 `CHK({vector_fetch, vector_addr}, {1'b1, RESET_VECTOR_LO})
      @(posedge clk_sys);
      #1 `CHK({cpu_run, cpu_halt}, 2'b10)
   endtask
   task automatic regs_reset;
      rd(OFS_ENABLE, 8'h10);
      rd(OFS_FLAG_ONE, 8'h30);
      rd(OFS_WAKE_FLAG, 8'hC0);
      rd(OFS_WAKE_EDGE, 8'hC0);
      rd(OFS_EDGE_ONE, 8'h70);
      rd(5'h1C, 8'h00);
   endtask
   task automatic wake_scn;
      bus(1'b1, OFS_PIN_CFG, 32'h13F0F);
      bus(1'b1, OFS_WAKE_EDGE, 32'h20);
      wake_pin <= 6'h3E;
      settle;
      rd(OFS_WAKE_FLAG, 8'hE1);
      `CHK(int_req[4], 1'b0)
      bus(1'b1, OFS_ENABLE, 32'h20);
      settle;
      `CHK(int_req[4], 1'b1)
      bus(1'b1, OFS_WAKE_FLAG, 32'hFF);
      rd(OFS_WAKE_FLAG, 8'hE1);
      bus(1'b1, OFS_WAKE_FLAG, 32'h00);
      rd(OFS_WAKE_FLAG, 8'hC0);
   endtask
   task automatic vec_scn;
      bus(1'b1, OFS_EDGE_ONE, 32'h0A);
      vectored_pin <= 4'hA;
      settle;
      rd(OFS_FLAG_ONE, 8'h3F);
      bus(1'b1, OFS_ENABLE, 32'h05);
      settle;
      `CHK(int_req[4:0], 5'h05)
   endtask
   task automatic tmr_scn;
      bus(1'b1, OFS_ENABLE, 32'hC0);
      @(posedge clk_sys);
      timer_overflow <= 1'b1;
      sleep_direct_transfer <= 1'b1;
      @(posedge clk_sys);
      timer_overflow <= 1'b0;
      sleep_direct_transfer <= 1'b0;
      settle;
      `CHK(int_req[6:5], 2'b11)
      rd(OFS_FLAG_ONE, 8'hFF);
      bus(1'b1, OFS_FLAG_ONE, 32'h0F);
      rd(OFS_FLAG_ONE, 8'h3F);
      `CHK(int_req[6:5], 2'b00)
   endtask
   task automatic nmi_scn;
      bus(1'b1, OFS_EDGE_ONE, 32'h80);
      rd(OFS_EDGE_ONE, 8'hF0);
      nonmaskable_pin <= 1'b1;
      repeat (6) @(posedge clk_sys);
      #1 `CHK(nmi_req, 1'b1)
      repeat (14) @(posedge clk_sys);
      #1 `CHK(nmi_req, 1'b0)
   endtask
   task automatic mode_off_scn;
      vectored_pin <= 4'h4;
      wake_pin <= 6'h1E;
      repeat (8) @(posedge clk_sys);
      vectored_pin <= 4'h5;
      wake_pin <= 6'h1F;
      settle;
      rd(OFS_FLAG_ONE, 8'h30);
      rd(OFS_WAKE_FLAG, 8'hC0);
   endtask
   task automatic col_scn;
      bus(1'b1, OFS_ENABLE, 32'h01);
      cpu_imask <= 1'b0;
      bus(1'b1, OFS_FLAG_ONE, 32'hFE);
      rd(OFS_STATUS, 8'h81);
      settle;
      `CHK(int_req[0], 1'b0)
      cpu_imask <= 1'b1;
      timer_overflow <= 1'b1;
      bus(1'b1, OFS_FLAG_ONE, 32'h00);
      timer_overflow <= 1'b0;
      rd(OFS_FLAG_ONE, 8'h70);
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   initial begin
      {rst_n, avs_read, avs_write, nonmaskable_pin, timer_overflow} = '0;
      sleep_direct_transfer = 1'b0;
      cpu_imask = 1'b1;
      avs_address = '0;
      avs_writedata = '0;
      vectored_pin = 4'h5;
      wake_pin = 6'h1F;
      repeat (16) @(posedge clk_sys);
      `CHK({cpu_halt, nmi_req, int_req}, 9'h100)
      rst_n <= 1'b1;
      reset_entry;
      regs_reset;
      mode_off_scn;
      wake_scn;
      vec_scn;
      tmr_scn;
      nmi_scn;
      col_scn;
      print_verdict;
   end
endmodule
